// *** amcp_pkg.sv ***
// Package for the converter mode configuration port.
// Assumes one 20 MHz system clock; all pins arrive asynchronously.
package amcp_pkg;
    localparam int unsigned CLK_MHZ = 20;
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
    localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
    localparam logic [6:0] ADDR_CLK_TIMING = 7'h02;
    localparam logic [6:0] ADDR_DRIVER_MODE = 7'h03;
    localparam logic [6:0] ADDR_FORMAT = 7'h04;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam int unsigned SOFT_RESET_BIT = 7;
    localparam int unsigned WORD_BITS = 16;
    localparam logic [4:0] WORD_BITS_CNT = 5'h10;
    localparam logic [4:0] READ_START_CNT = 5'h08;
    // Nap recovery, in sample clock cycles
    localparam logic [7:0] NAP_RECOVER_CYCLES = 8'h64;
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_NAP = 2'h1;
    localparam logic [1:0] PWR_SLEEP = 2'h3;
    localparam logic [1:0] FMT_FULL_SE = 2'h0;
    localparam logic [1:0] FMT_DDR_DIFF = 2'h1;
    localparam logic [1:0] FMT_DDR_SE = 2'h2;
    localparam logic [2:0] CUR_3P5MA = 3'h0;
    localparam logic [2:0] TP_OFF = 3'h0;
    localparam logic [2:0] TP_ZEROS = 3'h1;
    localparam logic [2:0] TP_ONES = 3'h3;
    localparam logic [2:0] TP_CHECKER = 3'h5;
    localparam logic [2:0] TP_ALTERNATE = 3'h7;
    localparam logic [14:0] CHECKER_A = 15'h5555;
    localparam logic [13:0] ODD_BITS_MASK = 14'h2aaa;
    localparam logic [13:0] MSB_FLIP = 14'h2000;
endpackage : amcp_pkg

// *** amcp_mode_config_port.sv ***
// Mode configuration port of a 14-bit converter: strap, serial port, mode
// registers and output formatting. Assumes pins are asynchronous to mclk_in
// and that the serial clock is far slower than mclk_in.
// Read-back bits lag the host's SCK fall by about five clocks.
//
// Contract
// - Strap high: pins are static mode inputs
// - Parallel chip-select level sets stabilizer
// - Parallel SCK level selects output format
// - Parallel SDI high puts converter asleep
// - Strap low: pins form serial port
// - Transfer framed by chip-select; 16 edges sampled
// - Word: flag, address, data, MSB first
// - Write stores data; read returns register
// - SDO only pulls low, open drain
// - Reset bit clears all registers, self-clears
// - Power field: normal, nap, sleep
// - Timing bit 3 inverts output clock
// - Timing bits 2-1 pick phase delay
// - Timing bit 0 enables stabilizer
// - Driver current field in bits 6-4
// - Termination bit scales current 1.6 times
// - Output mode bit 2 makes outputs high-z
// - Output format field in bits 1-0
// - Test pattern field in bits 5-3
// - Format bits: polarity, scramble, signed
// - Scrambler XORs upper bits with LSB
// - Test pattern overrides all formatting
// - Nap exit needs 100 sample clocks
`timescale 1ns/10ps
`default_nettype none
module amcp_mode_config_port (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic interface_select_strap_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic sample_clk_in,
    input wire logic [13:0] raw_sample_in,
    input wire logic raw_overrange_in,
    output logic duty_cycle_stabilizer_enable_out,
    output logic [1:0] output_format_field_out,
    output logic [1:0] power_state_field_out,
    output logic output_clock_invert_out,
    output logic [1:0] output_clock_phase_field_out,
    output logic [2:0] diff_drive_current_field_out,
    output logic diff_termination_enable_out,
    output logic output_high_z_enable_out,
    output logic conversion_valid_out,
    output logic [13:0] sample_data_bits_out,
    output logic overrange_flag_out
);
    import amcp_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] strap_s_q, cs_s_q, sck_s_q, sdi_s_q, sclk_s_q;
    logic strap_q, cs_n_q, sck_q, sdi_q, sclk_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_s_q <= 3'h0;
            cs_s_q <= 3'h7;
            sck_s_q <= 3'h0;
            sdi_s_q <= 3'h0;
            sclk_s_q <= 3'h0;
        end else begin
            strap_s_q <= {strap_s_q[1:0], interface_select_strap_in};
            cs_s_q <= {cs_s_q[1:0], cs_n_in};
            sck_s_q <= {sck_s_q[1:0], sck_in};
            sdi_s_q <= {sdi_s_q[1:0], sdi_in};
            sclk_s_q <= {sclk_s_q[1:0], sample_clk_in};
        end
    end

    // Level moves only once stages two and three agree
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_q <= 1'b0;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            sdi_q <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            if (strap_s_q[1] == strap_s_q[2]) strap_q <= strap_s_q[2];
            if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
            if (sck_s_q[1] == sck_s_q[2]) sck_q <= sck_s_q[2];
            if (sdi_s_q[1] == sdi_s_q[2]) sdi_q <= sdi_s_q[2];
            if (sclk_s_q[1] == sclk_s_q[2]) sclk_q <= sclk_s_q[2];
        end
    end

    logic serial_mode;
    logic sck_rise, sck_fall, cs_fall, cs_rise, sclk_rise;
    logic sck_d1_q, cs_d1_q, sclk_d1_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_d1_q <= 1'b0;
            cs_d1_q <= 1'b1;
            sclk_d1_q <= 1'b0;
        end else begin
            sck_d1_q <= sck_q;
            cs_d1_q <= cs_n_q;
            sclk_d1_q <= sclk_q;
        end
    end

    assign serial_mode = !strap_q;
    assign sck_rise = sck_q && !sck_d1_q;
    assign sck_fall = !sck_q && sck_d1_q;
    assign cs_fall = !cs_n_q && cs_d1_q;
    assign cs_rise = cs_n_q && !cs_d1_q;
    assign sclk_rise = sclk_q && !sclk_d1_q;

    // ----------------------------------------------------------------
    // Serial shift engine
    // ----------------------------------------------------------------
    logic [15:0] shift_q;
    logic [4:0] bit_cnt_q;
    logic active_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_q <= 1'b0;
            bit_cnt_q <= 5'h0;
            shift_q <= 16'h0;
        end else if (!serial_mode || cs_rise) begin
            active_q <= 1'b0;
        end else if (cs_fall) begin
            active_q <= 1'b1;
            bit_cnt_q <= 5'h0;
        end else if (active_q && sck_rise && bit_cnt_q < WORD_BITS_CNT) begin
            shift_q <= {shift_q[14:0], sdi_q};
            bit_cnt_q <= bit_cnt_q + 5'h1;
        end
    end

    logic word_read, word_done;
    logic [6:0] word_addr;
    assign word_read = shift_q[15];
    assign word_addr = shift_q[14:8];
    assign word_done = active_q && cs_rise && bit_cnt_q == WORD_BITS_CNT;

    // ----------------------------------------------------------------
    // Mode control registers
    // ----------------------------------------------------------------
    logic [1:0] pwr_q;
    logic [3:0] timing_q;
    logic [6:0] drive_q;
    logic [5:0] format_q;

    // Commit at the word's end, so a reset applies when the write completes
    logic wr_go, soft_clr;
    assign wr_go = word_done && !word_read;
    // Self-clearing: the reset bit is never stored, only acted on at commit
    assign soft_clr = wr_go && word_addr == ADDR_SOFT_RESET && shift_q[SOFT_RESET_BIT];

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwr_q <= REG_RESET_VAL[1:0];
        end else if (soft_clr) begin
            pwr_q <= REG_RESET_VAL[1:0];
        end else if (wr_go && word_addr == ADDR_POWER_DOWN) begin
            pwr_q <= shift_q[1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timing_q <= REG_RESET_VAL[3:0];
        end else if (soft_clr) begin
            timing_q <= REG_RESET_VAL[3:0];
        end else if (wr_go && word_addr == ADDR_CLK_TIMING) begin
            timing_q <= shift_q[3:0];
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drive_q <= REG_RESET_VAL[6:0];
        end else if (soft_clr) begin
            drive_q <= REG_RESET_VAL[6:0];
        end else if (wr_go && word_addr == ADDR_DRIVER_MODE) begin
            drive_q <= shift_q[6:0];
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            format_q <= REG_RESET_VAL[5:0];
        end else if (soft_clr) begin
            format_q <= REG_RESET_VAL[5:0];
        end else if (wr_go && word_addr == ADDR_FORMAT) begin
            format_q <= shift_q[5:0];
        end
    end

    function automatic logic [7:0] reg_read(input logic [6:0] addr);
        case (addr)
            ADDR_POWER_DOWN: reg_read = {6'h0, pwr_q};
            ADDR_CLK_TIMING: reg_read = {4'h0, timing_q};
            ADDR_DRIVER_MODE: reg_read = {1'b0, drive_q};
            ADDR_FORMAT: reg_read = {2'h0, format_q};
            default: reg_read = 8'h00; // Reset register is write only
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Read-back on open-drain SDO
    // ----------------------------------------------------------------
    logic [7:0] rd_shift_q;
    logic rd_on_q;

    // Address is complete after eight bits; data then leaves on falling edges
    // Filter delay puts each bit about five clocks behind the SCK fall, so a
    // host must sample late in the high phase, not right at the rise
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_shift_q <= 8'hff;
            rd_on_q <= 1'b0;
        end else if (!active_q || !serial_mode) begin
            rd_on_q <= 1'b0;
            rd_shift_q <= 8'hff;
        end else if (sck_fall && bit_cnt_q == READ_START_CNT && shift_q[7]) begin
            rd_on_q <= 1'b1;
            rd_shift_q <= reg_read(shift_q[6:0]);
        end else if (sck_fall && rd_on_q && bit_cnt_q > READ_START_CNT) begin
            rd_shift_q <= {rd_shift_q[6:0], 1'b1};
        end
    end

    assign sdo_out = 1'b0;
    assign sdo_oe_out = rd_on_q && !rd_shift_q[7];

    // ----------------------------------------------------------------
    // Mode outputs, strap selects source
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            duty_cycle_stabilizer_enable_out <= 1'b0;
            output_format_field_out <= FMT_FULL_SE;
            power_state_field_out <= PWR_NORMAL;
            output_clock_invert_out <= 1'b0;
            output_clock_phase_field_out <= 2'h0;
            diff_drive_current_field_out <= CUR_3P5MA;
            diff_termination_enable_out <= 1'b0;
            output_high_z_enable_out <= 1'b0;
        end else if (!serial_mode) begin
            // Pin level itself, not the select sense: high turns it on
            duty_cycle_stabilizer_enable_out <= cs_n_q;
            output_format_field_out <= sck_q ? FMT_DDR_DIFF : FMT_FULL_SE;
            power_state_field_out <= sdi_q ? PWR_SLEEP : PWR_NORMAL;
            output_clock_invert_out <= 1'b0;
            output_clock_phase_field_out <= 2'h0;
            diff_drive_current_field_out <= CUR_3P5MA;
            diff_termination_enable_out <= 1'b0;
            output_high_z_enable_out <= 1'b0;
        end else begin
            duty_cycle_stabilizer_enable_out <= timing_q[0];
            output_format_field_out <= drive_q[1:0];
            power_state_field_out <= pwr_q;
            output_clock_invert_out <= timing_q[3];
            output_clock_phase_field_out <= timing_q[2:1];
            diff_drive_current_field_out <= drive_q[6:4];
            diff_termination_enable_out <= drive_q[3];
            output_high_z_enable_out <= drive_q[2];
        end
    end

    // ----------------------------------------------------------------
    // Nap recovery counter
    // ----------------------------------------------------------------
    logic [7:0] wake_cnt_q;
    logic powered;
    assign powered = power_state_field_out == PWR_NORMAL;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_cnt_q <= NAP_RECOVER_CYCLES;
        end else if (!powered) begin
            wake_cnt_q <= 8'h0;
        end else if (sclk_rise && wake_cnt_q < NAP_RECOVER_CYCLES) begin
            wake_cnt_q <= wake_cnt_q + 8'h1;
        end
    end
    assign conversion_valid_out = powered && wake_cnt_q == NAP_RECOVER_CYCLES;

    // ----------------------------------------------------------------
    // Output data formatting
    // ----------------------------------------------------------------
    logic [2:0] tp;
    logic [2:0] fsel;
    logic alt_q;
    assign tp = serial_mode ? format_q[5:3] : TP_OFF;
    // Parallel mode has no format register, so data leaves as offset binary
    assign fsel = serial_mode ? format_q[2:0] : 3'h0;

    // Order: signed flip, scrambler, odd-bit inversion; none touches the LSB first
    function automatic logic [13:0] fmt_sample(input logic [13:0] raw_val,
            input logic [2:0] sel);
        logic [13:0] d;
        d = raw_val;
        if (sel[0] && !sel[2]) begin
            d = d ^ MSB_FLIP;
        end
        if (sel[1]) begin
            d = d ^ {{13{d[0]}}, 1'b0};
        end
        if (sel[2]) begin
            d = d ^ ODD_BITS_MASK;
        end
        fmt_sample = d;
    endfunction

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) alt_q <= 1'b0;
        else if (sclk_rise) alt_q <= !alt_q;
    end

    // Applied per sample clock; raw data assumed stable at its edge
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sample_data_bits_out <= 14'h0;
            overrange_flag_out <= 1'b0;
        end else if (sclk_rise) begin
            case (tp)
                TP_ZEROS: {overrange_flag_out, sample_data_bits_out} <= 15'h0;
                TP_ONES: {overrange_flag_out, sample_data_bits_out} <= 15'h7fff;
                TP_CHECKER: {overrange_flag_out, sample_data_bits_out} <=
                    alt_q ? ~CHECKER_A : CHECKER_A;
                TP_ALTERNATE: {overrange_flag_out, sample_data_bits_out} <=
                    alt_q ? 15'h7fff : 15'h0;
                default: begin
                    sample_data_bits_out <= fmt_sample(raw_sample_in, fsel);
                    overrange_flag_out <= raw_overrange_in;
                end
            endcase
        end
    end

endmodule // amcp_mode_config_port
`default_nettype wire

// *** amcp_monitor.sv ***
// Pin-level checks on the mode configuration port.
// Assumes it is bound into amcp_mode_config_port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module amcp_monitor (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic interface_select_strap_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic duty_cycle_stabilizer_enable_out,
    input wire logic [1:0] output_format_field_out,
    input wire logic [1:0] power_state_field_out,
    input wire logic [1:0] output_clock_phase_field_out,
    input wire logic [2:0] diff_drive_current_field_out,
    input wire logic diff_termination_enable_out,
    input wire logic conversion_valid_out
);
    // --------
    // Properties
    // --------
    // Eight cycles cover the pin filter plus the output register
    default clocking mon_cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sdo_drive_low_a: assert property (sdo_out == 1'b0)
        else $error("sdo driven high");
    sdo_frame_only_a: assert property (cs_n_in [*8] |-> !sdo_oe_out)
        else $error("sdo active outside a frame");
    par_stabilizer_a: assert property ((interface_select_strap_in && $stable(cs_n_in)) [*8]
        |-> duty_cycle_stabilizer_enable_out == cs_n_in) else $error("stabilizer not cs level");
    par_format_a: assert property ((interface_select_strap_in && $stable(sck_in)) [*8]
        |-> output_format_field_out == {1'b0, sck_in} && diff_drive_current_field_out == 3'h0
        && !diff_termination_enable_out) else $error("format not sck level");
    par_sleep_a: assert property ((interface_select_strap_in && $stable(sdi_in)) [*8]
        |-> power_state_field_out == {2{sdi_in}}) else $error("sleep not sdi level");
    valid_gate_a: assert property (power_state_field_out != 2'h0 |=> !conversion_valid_out)
        else $error("valid while powered down");
    nap_recover_a: assert property ($rose(power_state_field_out == 2'h0)
        |-> !conversion_valid_out [*8]) else $error("valid too soon after wake");
    frame_hold_a: assert property ((!interface_select_strap_in && cs_n_in) [*8]
        |=> $stable(power_state_field_out) && $stable(output_clock_phase_field_out)
        && $stable(output_format_field_out)) else $error("mode changed outside a frame");
endmodule // amcp_monitor
bind amcp_mode_config_port amcp_monitor mon_u (.mclk_in, .reset_n_in,
    .interface_select_strap_in, .cs_n_in, .sck_in, .sdi_in, .sdo_out, .sdo_oe_out,
    .duty_cycle_stabilizer_enable_out, .output_format_field_out, .power_state_field_out,
    .output_clock_phase_field_out, .diff_drive_current_field_out,
    .diff_termination_enable_out, .conversion_valid_out);
`default_nettype wire

// *** amcp_host_model.sv ***
// Host controller on the configuration pins.
// Assumes the bench resolves the open-drain SDO line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module amcp_host_model (
    input wire logic mclk_in,
    input wire logic sdo_line_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out,
    output logic [7:0] rd_data_out
);
    // --------
    // Pin drivers
    // --------
    initial begin
        {cs_n_out, sck_out, sdi_out} = 3'h4;
        rd_data_out = 8'h00;
    end
    task automatic set_pins(input logic cs, input logic ck, input logic di);
        @(negedge mclk_in);
        {cs_n_out, sck_out, sdi_out} = {cs, ck, di};
    endtask
    // Word MSB first; a count other than 16 exercises framing
    task automatic xfer(input logic [15:0] word, input int nbits);
        int i;
        repeat (4) @(negedge mclk_in);
        cs_n_out = 1'b0;
        for (i = 15; i > 15 - nbits; i--) begin
            repeat (2) @(negedge mclk_in);
            sdi_out = (i >= 0) ? word[i] : ~word[0];
            repeat (2) @(negedge mclk_in);
            sck_out = 1'b1;
            repeat (4) @(negedge mclk_in);
            // Read bit lags the fall by the pin filter; take it at the end of the high phase
            if (i >= 0 && i < 8) rd_data_out = {rd_data_out[6:0], sdo_line_in};
            sck_out = 1'b0;
        end
        repeat (4) @(negedge mclk_in);
        cs_n_out = 1'b1;
        // Released line must not keep showing the last bit
        sdi_out = ~sdi_out;
    endtask
endmodule // amcp_host_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: serial registers, formatting, nap and strap-high modes.
// Assumes amcp_pkg, the design, the host model and the monitor compile first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import amcp_pkg::*;
    localparam logic [2:0] TP_CODE [4] = '{TP_ZEROS, TP_ONES, TP_CHECKER, TP_ALTERNATE};
    localparam logic [14:0] TP_VAL [4] = '{15'h0000, 15'h7fff, CHECKER_A, 15'h0000};
    // Unused register bits are not stored and read back as zero
    localparam logic [7:0] RD_MASK [1:4] = '{8'h03, 8'h0f, 8'h7f, 8'h3f};
    logic [15:0] prev_pat = 16'h0000;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic strap = 1'b0;
    logic sample_clk = 1'b0;
    logic [14:0] raw = 15'h0000;
    logic [7:0] regs [1:4];
    logic vld = 1'b1;
    logic [17:0] note_q [$];
    event obs_ev;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 97026;
    wire logic cs_n, sck, sdi, sdo, sdo_oe, duty_cycle_stabilizer_enable, inv, term, hiz, valid, of;
    wire logic [1:0] fmt, pwr, phase;
    wire logic [2:0] cur;
    wire logic [13:0] data;
    wire logic [7:0] rd;
    wire logic sdo_line = sdo_oe ? sdo : 1'b1;
    always #25 mclk_in = ~mclk_in;
    amcp_mode_config_port dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .interface_select_strap_in(strap), .cs_n_in(cs_n), .sck_in(sck), .sdi_in(sdi),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sample_clk_in(sample_clk),
        .raw_sample_in(raw[13:0]), .raw_overrange_in(raw[14]),
        .duty_cycle_stabilizer_enable_out(duty_cycle_stabilizer_enable), .output_format_field_out(fmt),
        .power_state_field_out(pwr), .output_clock_invert_out(inv),
        .output_clock_phase_field_out(phase), .diff_drive_current_field_out(cur),
        .diff_termination_enable_out(term), .output_high_z_enable_out(hiz),
        .conversion_valid_out(valid), .sample_data_bits_out(data), .overrange_flag_out(of));
    amcp_host_model host_u (.mclk_in(mclk_in), .sdo_line_in(sdo_line), .cs_n_out(cs_n),
        .sck_out(sck), .sdi_out(sdi), .rd_data_out(rd));
    // --------
    // Expectations and drivers
    // --------
    function automatic logic [15:0] mexp(input logic v, input logic [7:0] r1,
            input logic [7:0] r2, input logic [7:0] r3);
        return {2'b00, v, r2[0], r3[1:0], r1[1:0], r2[3:1], r3[6:2]};
    endfunction
    function automatic logic [14:0] fexp(input logic [2:0] f, input logic [14:0] r);
        logic [13:0] d;
        d = r[13:0];
        if (f[0] && !f[2]) d = d ^ MSB_FLIP;
        if (f[1]) d[13:1] = d[13:1] ^ {13{d[0]}};
        if (f[2]) d = d ^ ODD_BITS_MASK;
        return {r[14], d};
    endfunction
    task automatic chk(input logic [1:0] k, input logic [15:0] v);
        note_q.push_back({k, v});
        repeat (12) @(negedge mclk_in);
        -> obs_ev;
    endtask
    task automatic chk_mode();
        chk(2'h0, mexp(vld, regs[1], regs[2], regs[3]));
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a, d}, 16);
        if (a == ADDR_SOFT_RESET && d[SOFT_RESET_BIT]) regs = '{default: 8'h00};
        else if (a >= ADDR_POWER_DOWN && a <= ADDR_FORMAT) regs[a] = d & RD_MASK[a];
    endtask
    task automatic rd_chk(input logic [6:0] a);
        logic [7:0] e;
        e = (a >= ADDR_POWER_DOWN && a <= ADDR_FORMAT) ? regs[a] : 8'h00;
        host_u.xfer({1'b1, a, 8'($random(seed))}, 16);
        chk(2'h1, {8'h00, e});
    endtask
    task automatic samp(input logic [14:0] v);
        raw = v;
        repeat (4) @(negedge mclk_in);
        sample_clk = 1'b1;
        repeat (6) @(negedge mclk_in);
        sample_clk = 1'b0;
        repeat (6) @(negedge mclk_in);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Checkerboard and alternating phase is free-running, so either phase passes
    always @(obs_ev) begin
        logic [17:0] n;
        logic [15:0] got;
        logic ok;
        n = note_q.pop_front();
        case (n[17:16])
            2'h0: got = {2'b00, valid, duty_cycle_stabilizer_enable, fmt, pwr, inv, phase, cur, term, hiz};
            2'h1: got = {8'h00, rd};
            default: got = {1'b0, of, data};
        endcase
        check_count++;
        ok = got === {1'b0, n[14:0]} || (n[17:16] == 2'h3 && got === {1'b0, ~n[14:0]});
        // Bit 15 of a pattern note asks for the complement of the previous sample
        if (n[17:16] == 2'h3 && n[15] && got !== (prev_pat ^ 16'h7fff)) ok = 1'b0;
        if (n[17:16] == 2'h3) prev_pat = got;
        if (!ok) begin
            error_cnt++;
            $display("CHECK FAILED %0t kind %0d got %h exp %h", $time, n[17:16], got, n[15:0]);
        end
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        int i;
        logic [14:0] v;
        regs = '{default: 8'h00};
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in);
        reset_n_in = 1'b1;
        repeat (10) @(negedge mclk_in);
        wr(ADDR_SOFT_RESET, 8'h80);
        chk_mode();
        for (i = 0; i < 6; i++) rd_chk(i[6:0]);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CLK_TIMING, {4'($random(seed)), i[0], i[2:1], |i[2:0]});
            wr(ADDR_DRIVER_MODE, {1'b0, i[2:0], 2'($random(seed)), i[1:0]});
            chk_mode();
            rd_chk(ADDR_CLK_TIMING);
            rd_chk(ADDR_DRIVER_MODE);
            chk_mode();
        end
        host_u.xfer({1'b0, ADDR_CLK_TIMING, 8'h0b}, 17);
        regs[2] = 8'h0b;
        chk_mode();
        host_u.xfer({1'b0, ADDR_CLK_TIMING, 8'h00}, 15);
        chk_mode();
        wr(7'h05, 8'hff);
        wr(ADDR_SOFT_RESET, 8'h7f);
        chk_mode();
        wr(ADDR_SOFT_RESET, 8'h80 | 8'($random(seed)));
        chk_mode();
        rd_chk(ADDR_CLK_TIMING);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_FORMAT, {5'h00, i[2:0]});
            v = 15'($random(seed));
            samp(v);
            chk(2'h2, {1'b0, fexp(i[2:0], v)});
        end
        for (i = 0; i < 8; i++) begin
            wr(ADDR_FORMAT, {2'b00, TP_CODE[i / 2], 3'h7});
            samp(15'($random(seed)));
            chk(TP_CODE[i / 2][2] ? 2'h3 : 2'h2, {i[0], TP_VAL[i / 2]});
        end
        vld = 1'b0;
        wr(ADDR_POWER_DOWN, {6'h00, PWR_NAP});
        chk_mode();
        wr(ADDR_POWER_DOWN, {6'h00, PWR_SLEEP});
        chk_mode();
        wr(ADDR_POWER_DOWN, {6'h00, PWR_NORMAL});
        chk_mode();
        repeat (99) samp(15'($random(seed)));
        chk_mode();
        vld = 1'b1;
        samp(15'($random(seed)));
        chk_mode();
        // Pins and strap move in one step so no stale serial level looks like sleep
        host_u.set_pins(1'b0, 1'b0, 1'b0);
        strap = 1'b1;
        for (i = 0; i < 8; i++) begin
            host_u.set_pins(i[0], i[1], i[2]);
            vld = vld & ~i[2];
            chk(2'h0, mexp(vld, {6'h00, {2{i[2]}}}, {7'h00, i[0]}, {7'h00, i[1]}));
        end
        @(negedge mclk_in);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
